// ==== design/psc_pkg.sv ====
package psc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  PSC_OFF_STATE    = 8'h00;
  localparam logic [7:0]  PSC_OFF_EVENT    = 8'h04;
  localparam logic [7:0]  PSC_OFF_MASK     = 8'h08;
  localparam int          PSC_NUM_EVT      = 5;
  localparam logic [4:0]  PSC_MASK_RST     = 5'h00;

  // State register fields
  localparam int          PSC_ST_STATE_LSB = 0;
  localparam int          PSC_ST_PRIV_BIT  = 3;
  localparam int          PSC_ST_SR_LSB    = 4;
  localparam int          PSC_ST_SAVED_LSB = 9;
  localparam int          PSC_ST_VEC_LSB   = 16;

  // Event bit positions
  localparam int          PSC_EVB_PRIV     = 0;
  localparam int          PSC_EVB_EXC      = 1;
  localparam int          PSC_EVB_HALT     = 2;
  localparam int          PSC_EVB_STOP     = 3;
  localparam int          PSC_EVB_BERR     = 4;

  // ----------------------------------------------------------------
  // Vectors, priority and reference class codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  PSC_VEC_RESET    = 8'h00;
  localparam logic [7:0]  PSC_VEC_BERR     = 8'h02;
  localparam logic [7:0]  PSC_VEC_PRIV     = 8'h08;
  localparam logic [7:0]  PSC_VEC_TRACE    = 8'h09;
  localparam logic [2:0]  PSC_IPM_MAX      = 3'h7;
  localparam logic [2:0]  PSC_RC_USER_DATA = 3'h1;
  localparam logic [2:0]  PSC_RC_USER_PROG = 3'h2;
  localparam logic [2:0]  PSC_RC_SUP_DATA  = 3'h5;
  localparam logic [2:0]  PSC_RC_SUP_PROG  = 3'h6;
  localparam logic [2:0]  PSC_RC_IACK      = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PSC_NORMAL   = 3'b000,
    PSC_EXC_COPY = 3'b001,
    PSC_EXC_VEC  = 3'b011,
    PSC_EXC_SAVE = 3'b010,
    PSC_EXC_LOAD = 3'b110,
    PSC_STOPPED  = 3'b100,
    PSC_HALTED   = 3'b111
  } psc_state_t;

  typedef enum logic [1:0] {
    PSC_EXK_RESET = 2'b00,
    PSC_EXK_BERR  = 2'b01,
    PSC_EXK_INT   = 2'b11,
    PSC_EXK_OTHER = 2'b10
  } psc_exk_t;

  typedef struct packed {
    logic       t;
    logic       s;
    logic [2:0] ipm;
  } psc_sr_t;

  localparam psc_sr_t     PSC_SR_RST       = '{t: 1'b0, s: 1'b1, ipm: 3'h7};

  typedef struct packed {
    logic stop;
    logic reset_op;
    logic sr_write;
    logic user_stack_pointer_move;
  } psc_instr_t;

  typedef struct packed {
    logic reference_class_msb;
    logic reference_class_mid;
    logic reference_class_lsb;
  } psc_ref_class_t;

endpackage : psc_pkg

// ==== design/psc_ref_class_enc.sv ====
`timescale 1ns/1ns
`default_nettype none
module psc_ref_class_enc
  import psc_pkg::*;
(
  // Reference kind
  input  wire logic     supervisor,
  input  wire logic     prog_space,
  input  wire logic     iack,
  // Class code
  output psc_ref_class_t ref_class
);

  // ----------------------------------------------------------------
  // Encoder
  // ----------------------------------------------------------------
  // Only the five assigned codes can come out of this table
  always_comb
  begin
    if (iack)
      ref_class = PSC_RC_IACK;
    else if (supervisor)
      ref_class = prog_space ? PSC_RC_SUP_PROG : PSC_RC_SUP_DATA;
    else
      ref_class = prog_space ? PSC_RC_USER_PROG : PSC_RC_USER_DATA;
  end

endmodule : psc_ref_class_enc
`default_nettype wire

// ==== design/psc_classifier.sv ====
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Exactly one processing state at any time
// - Stop instruction enters stopped, no references
// - Bus error during bus error handling halts
// - Halted is left only by reset
// - Stopped and halted are separate states
// - Privilege follows the supervisor flag
// - Supervisor runs all, classes supervisor references
// - Stack select follows privilege level
// - Exception processing supervisor class, except interrupt acknowledge class
// - Exception stacking uses supervisor stack
// - User level refuses the privileged instructions
// - User level rises only through exceptions
// - Save flag, then set it on entry
// - Three-bit class code, unassigned codes never
// - Four ordered exception steps
// - Step one clears trace, updates mask on reset and interrupt
// - Vector address is number times four
module psc_classifier
  import psc_pkg::*;
#(
  parameter int unsigned IPL_W = 3
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Core instruction side
  input  wire logic        instr_valid,
  input  wire psc_instr_t  instr_kind,
  input  wire psc_sr_t     sr_wr_data,
  input  wire logic        exc_req,
  input  wire logic [7:0]  exc_vector,
  input  wire logic        save_done,
  input  wire logic        load_done,
  // Bus side
  input  wire logic        bus_start,
  input  wire logic        bus_program,
  input  wire logic        bus_error,
  input  wire logic        iack_done,
  input  wire logic [7:0]  iack_vector,
  input  wire logic [IPL_W-1:0] irq_level_pin,
  // Status outputs
  output psc_ref_class_t   ref_class,
  output logic             bus_enable,
  output logic             supervisor,
  output logic             sel_user_stack_pointer,
  output logic [9:0]       vector_addr,
  output logic [2:0]       proc_state,
  output logic             instr_done,
  output logic             instr_refused,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  psc_state_t       state_q;
  psc_exk_t         kind_q;
  psc_sr_t          sr_q;
  psc_sr_t          saved_q;
  logic [7:0]       vec_q;
  logic [IPL_W-1:0] lvl_s1_q;
  logic [IPL_W-1:0] lvl_s2_q;
  logic [IPL_W-1:0] lvl_s3_q;
  logic [IPL_W-1:0] lvl_q;
  logic [PSC_NUM_EVT-1:0] evt_q;
  logic [PSC_NUM_EVT-1:0] evt_set;
  logic [PSC_NUM_EVT-1:0] mask_q;
  logic [PSC_NUM_EVT-1:0] evt_d;
  psc_ref_class_t   class_d;
  psc_ref_class_t   class_q;
  logic             in_exc;
  logic             priv_instr;
  logic             priv_viol;
  logic             exec_ok;
  logic             int_pend;
  logic             trace_take;
  logic             take_exc;
  psc_exk_t         take_kind;
  logic [7:0]       take_vec;
  logic             apb_wr;
  logic             apb_rd;
  logic             ev_clear;
  logic [31:0]      state_word;
  logic             bus_enable_q;
  logic             supervisor_q;
  logic             sel_usp_q;
  logic [9:0]       vaddr_q;
  logic             done_q;
  logic             refused_q;
  logic             irq_q;
  logic [31:0]      prdata_q;
  logic             pready_q;
  logic             pslverr_q;

  // The mask compare and the status field are built for three level pins
  if (IPL_W != 3)
  begin : g_bad_ipl_w
    $error("psc_classifier: IPL_W must be 3");
  end

  // ----------------------------------------------------------------
  // Interrupt level pins
  // ----------------------------------------------------------------
  // Stage one feeds stage two only; a level counts once two and three agree
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lvl_s1_q <= '0;
      lvl_s2_q <= '0;
      lvl_s3_q <= '0;
      lvl_q    <= '0;
    end
    else
    begin
      lvl_s1_q <= irq_level_pin;
      lvl_s2_q <= lvl_s1_q;
      lvl_s3_q <= lvl_s2_q;
      if (lvl_s2_q == lvl_s3_q)
        lvl_q <= lvl_s3_q;
    end
  end

  // ----------------------------------------------------------------
  // Exception selection
  // ----------------------------------------------------------------
  assign in_exc     = (state_q == PSC_EXC_COPY) || (state_q == PSC_EXC_VEC) ||
                      (state_q == PSC_EXC_SAVE) || (state_q == PSC_EXC_LOAD);
  assign priv_instr = instr_valid & (instr_kind.stop | instr_kind.reset_op |
                      instr_kind.sr_write | instr_kind.user_stack_pointer_move);
  assign priv_viol  = priv_instr & ~sr_q.s & (state_q == PSC_NORMAL);
  assign exec_ok    = instr_valid & (state_q == PSC_NORMAL) & ~bus_error &
                      ~exc_req & ~priv_viol;
  assign int_pend   = (lvl_q == PSC_IPM_MAX) || (lvl_q > sr_q.ipm);
  assign trace_take = exec_ok & sr_q.t;

  // Fixed priority; a stop with trace set traces instead of stopping
  always_comb
  begin
    take_exc  = 1'b1;
    take_kind = PSC_EXK_OTHER;
    take_vec  = exc_vector;
    if (bus_error)
    begin
      take_kind = PSC_EXK_BERR;
      take_vec  = PSC_VEC_BERR;
    end
    else if (exc_req)
      take_vec = exc_vector;
    else if (priv_viol)
      take_vec = PSC_VEC_PRIV;
    else if (trace_take)
      take_vec = PSC_VEC_TRACE;
    else if (int_pend)
      take_kind = PSC_EXK_INT;
    else
      take_exc = 1'b0;
  end

  // ----------------------------------------------------------------
  // Processing state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= PSC_EXC_COPY;
      kind_q  <= PSC_EXK_RESET;
    end
    else
    begin
      unique case (state_q)
        PSC_NORMAL:
        begin
          if (take_exc)
          begin
            state_q <= PSC_EXC_COPY;
            kind_q  <= take_kind;
          end
          else if (exec_ok && instr_kind.stop)
            state_q <= PSC_STOPPED;
        end
        PSC_STOPPED:
        begin
          if (int_pend)
          begin
            state_q <= PSC_EXC_COPY;
            kind_q  <= PSC_EXK_INT;
          end
        end
        PSC_HALTED:
          state_q <= PSC_HALTED;
        default:
        begin
          if (bus_error && (kind_q == PSC_EXK_BERR))
            state_q <= PSC_HALTED;
          else if (bus_error)
          begin
            state_q <= PSC_EXC_COPY;
            kind_q  <= PSC_EXK_BERR;
          end
          else
          begin
            unique case (state_q)
              PSC_EXC_COPY:
                state_q <= PSC_EXC_VEC;
              PSC_EXC_VEC:
              begin
                if (kind_q != PSC_EXK_INT || iack_done)
                  state_q <= (kind_q == PSC_EXK_RESET) ? PSC_EXC_LOAD : PSC_EXC_SAVE;
              end
              PSC_EXC_SAVE:
              begin
                if (save_done)
                  state_q <= PSC_EXC_LOAD;
              end
              PSC_EXC_LOAD:
              begin
                if (load_done)
                  state_q <= PSC_NORMAL;
              end
              default:
                state_q <= PSC_HALTED;
            endcase
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status flags and vector
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sr_q    <= PSC_SR_RST;
      saved_q <= PSC_SR_RST;
    end
    else if (state_q == PSC_EXC_COPY)
    begin
      saved_q <= sr_q;
      sr_q.s  <= 1'b1;
      sr_q.t  <= 1'b0;
      if (kind_q == PSC_EXK_RESET)
        sr_q.ipm <= PSC_IPM_MAX;
      else if (kind_q == PSC_EXK_INT)
        sr_q.ipm <= lvl_q;
    end
    else if (exec_ok && (instr_kind.sr_write || instr_kind.stop))
      sr_q <= sr_wr_data;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      vec_q <= PSC_VEC_RESET;
    else if (state_q == PSC_NORMAL && take_exc)
      vec_q <= take_vec;
    else if (state_q == PSC_EXC_COPY && kind_q == PSC_EXK_RESET)
      vec_q <= PSC_VEC_RESET;
    else if (state_q == PSC_EXC_COPY && kind_q == PSC_EXK_BERR)
      vec_q <= PSC_VEC_BERR;
    else if (state_q == PSC_EXC_VEC && kind_q == PSC_EXK_INT && iack_done)
      vec_q <= iack_vector;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      vaddr_q <= '0;
    else if (state_q == PSC_EXC_VEC)
      vaddr_q <= {(kind_q == PSC_EXK_INT && iack_done) ? iack_vector : vec_q, 2'b00};
  end

  // ----------------------------------------------------------------
  // Privilege, stack select and reference class
  // ----------------------------------------------------------------
  psc_ref_class_enc u_enc (
    .supervisor (sr_q.s | in_exc),
    .prog_space (bus_program),
    .iack       (state_q == PSC_EXC_VEC && kind_q == PSC_EXK_INT),
    .ref_class  (class_d)
  );

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      supervisor_q <= 1'b1;
      sel_usp_q    <= 1'b0;
      class_q      <= PSC_RC_SUP_PROG;
      bus_enable_q <= 1'b0;
    end
    else
    begin
      supervisor_q <= sr_q.s | in_exc;
      sel_usp_q    <= ~(sr_q.s | in_exc);
      bus_enable_q <= (state_q != PSC_STOPPED) && (state_q != PSC_HALTED);
      if (bus_start)
        class_q <= class_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      done_q    <= 1'b0;
      refused_q <= 1'b0;
    end
    else
    begin
      done_q    <= exec_ok;
      refused_q <= priv_viol & ~bus_error & ~exc_req;
    end
  end

  // ----------------------------------------------------------------
  // APB registers and interrupt
  // ----------------------------------------------------------------
  assign apb_wr   = psel & penable & pready_q & pwrite;
  assign apb_rd   = psel & penable & pready_q & ~pwrite;
  assign ev_clear = apb_rd & (paddr == PSC_OFF_EVENT);

  always_comb
  begin
    state_word = '0;
    state_word[PSC_ST_STATE_LSB +: 3] = state_q;
    state_word[PSC_ST_PRIV_BIT]       = sr_q.s | in_exc;
    state_word[PSC_ST_SR_LSB +: 5]    = sr_q;
    state_word[PSC_ST_SAVED_LSB +: 5] = saved_q;
    state_word[PSC_ST_VEC_LSB +: 8]   = vec_q;
    evt_set = '0;
    evt_set[PSC_EVB_PRIV] = priv_viol;
    evt_set[PSC_EVB_EXC]  = (state_q == PSC_EXC_COPY);
    evt_set[PSC_EVB_HALT] = in_exc && bus_error && (kind_q == PSC_EXK_BERR);
    evt_set[PSC_EVB_STOP] = exec_ok && instr_kind.stop && !take_exc;
    evt_set[PSC_EVB_BERR] = bus_error;
    // Only the bits the read returned are cleared; a later event survives
    evt_d = (evt_q & ~({PSC_NUM_EVT{ev_clear}} & prdata_q[PSC_NUM_EVT-1:0])) | evt_set;
  end

  // One wait-free access: answer is prepared in the setup cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & (paddr != PSC_OFF_STATE) &
                   (paddr != PSC_OFF_EVENT) & (paddr != PSC_OFF_MASK);
      if (psel && !penable)
      begin
        unique case (paddr)
          PSC_OFF_STATE: prdata_q <= state_word;
          PSC_OFF_EVENT: prdata_q <= {27'h000_0000, evt_q};
          PSC_OFF_MASK:  prdata_q <= {27'h000_0000, mask_q};
          default:       prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Read clears what it showed; an event in the clearing cycle stays set
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      evt_q  <= '0;
      mask_q <= PSC_MASK_RST;
      irq_q  <= 1'b0;
    end
    else
    begin
      evt_q <= evt_d;
      if (apb_wr && paddr == PSC_OFF_MASK)
        mask_q <= pwdata[PSC_NUM_EVT-1:0];
      irq_q <= |(evt_d & mask_q);
    end
  end

  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign ref_class              = class_q;
  assign bus_enable             = bus_enable_q;
  assign supervisor             = supervisor_q;
  assign sel_user_stack_pointer = sel_usp_q;
  assign vector_addr            = vaddr_q;
  assign proc_state             = state_q;
  assign instr_done             = done_q;
  assign instr_refused          = refused_q;
  assign irq                    = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_halt_sticky: assert property (state_q == PSC_HALTED |=> state_q == PSC_HALTED [*4])
    else $error("halted state was left without reset");
  chk_double_berr: assert property (in_exc && bus_error && kind_q == PSC_EXK_BERR
                                    |=> state_q == PSC_HALTED ##1 !bus_enable_q)
    else $error("second bus error did not halt");
  chk_exc_super: assert property (in_exc |=> supervisor_q && !sel_usp_q)
    else $error("exception processing not supervisor");
  chk_class_legal: assert property (class_q != 3'h0 && class_q != 3'h3 && class_q != 3'h4)
    else $error("unassigned reference class");
  chk_stop_quiet: assert property (state_q == PSC_STOPPED |=> !bus_enable_q)
    else $error("references enabled while stopped");
  chk_priv_trap: assert property (priv_viol && !bus_error && !exc_req
                                  |=> state_q == PSC_EXC_COPY && instr_refused ##1
                                  state_q == PSC_EXC_VEC && vec_q == PSC_VEC_PRIV)
    else $error("privilege violation not trapped");
  chk_copy_saves: assert property (state_q == PSC_EXC_COPY && !bus_error
                                   |=> sr_q.s && !sr_q.t && saved_q == $past(sr_q))
    else $error("status not saved and set");
  chk_step_order: assert property (state_q == PSC_EXC_SAVE |->
                                   $past(state_q) inside {PSC_EXC_VEC, PSC_EXC_SAVE})
    else $error("exception steps out of order");
  chk_user_raise: assert property ($rose(sr_q.s) |-> $past(state_q) == PSC_EXC_COPY)
    else $error("privilege raised outside exception");
  chk_priv_follow: assert property (state_q == PSC_NORMAL |=> supervisor_q == $past(sr_q.s))
    else $error("privilege level does not follow flag");
  chk_vec_times4: assert property (state_q == PSC_EXC_VEC && kind_q != PSC_EXK_INT
                                   |=> vaddr_q == {$past(vec_q), 2'b00})
    else $error("vector address not number times four");

  cov_priv_trap: cover property (priv_viol ##1 state_q == PSC_EXC_COPY);
  cov_halt: cover property (state_q == PSC_HALTED);
  cov_stop_wake: cover property (state_q == PSC_STOPPED ##[1:50] state_q == PSC_EXC_COPY);
  cov_iack: cover property (state_q == PSC_EXC_VEC && kind_q == PSC_EXK_INT && iack_done);

endmodule : psc_classifier
`default_nettype wire

// ==== tb/psc_mmu_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module psc_mmu_model
  import psc_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Bench control
  input  wire logic            fault_arm,
  input  wire logic            slow,
  input  wire logic [7:0]      iack_num,
  // Design bus side
  input  wire logic            bus_start,
  input  wire psc_ref_class_t  ref_class,
  output logic                 bus_error,
  output logic                 iack_done,
  output logic [7:0]           iack_vector
);
  logic s1_q;
  logic s2_q;
  logic hit;
  logic ack;

  // Class is loaded at the start edge, so it is judged a cycle later, or two when slow
  assign hit = slow ? s2_q : s1_q;
  assign ack = hit && (ref_class == PSC_RC_IACK);

  always_ff @(posedge clk)
  begin
    s1_q <= rst_n && bus_start;
    s2_q <= rst_n && s1_q;
  end

  always_ff @(posedge clk)
  begin
    iack_done   <= rst_n && ack;
    bus_error   <= rst_n && hit && fault_arm && !ack;
    // Released data lines alternate between the inverse and the last vector
    iack_vector <= !rst_n ? 8'h00 : ack ? iack_num : ~iack_vector;
  end
endmodule : psc_mmu_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import psc_pkg::*;
  // ----
  // Signals
  // ----
  logic           clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]     paddr, exc_vector, iack_vector, iack_num;
  logic [31:0]    pwdata, prdata, rd;
  logic           instr_valid, exc_req, save_done, load_done, bus_start, bus_program;
  logic           bus_error, iack_done, bus_enable, supervisor, sel_ustk, instr_done;
  logic           instr_refused, irq, fault_arm, slow;
  logic [2:0]     irq_level_pin, proc_state;
  logic [9:0]     vector_addr;
  psc_instr_t     instr_kind;
  psc_sr_t        sr_wr_data;
  psc_ref_class_t ref_class;
  int             n_fail, total_checks;

  psc_classifier #(.IPL_W(3)) dut (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .instr_valid, .instr_kind, .sr_wr_data, .exc_req, .exc_vector, .save_done, .load_done,
    .bus_start, .bus_program, .bus_error, .iack_done, .iack_vector, .irq_level_pin,
    .ref_class, .bus_enable, .supervisor, .sel_user_stack_pointer(sel_ustk), .vector_addr,
    .proc_state, .instr_done, .instr_refused, .irq);
  psc_mmu_model mmu (.clk, .rst_n, .fault_arm, .slow, .iack_num, .bus_start, .ref_class,
    .bus_error, .iack_done, .iack_vector);

  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  // ----
  // Shared tasks
  // ----
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wait_st(input logic [2:0] s);
    for (int i = 0; i < 400 && proc_state !== s; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("proc_state", s, proc_state);
    if (proc_state !== s) give_verdict();
  endtask : wait_st

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (i == 50)
    begin
      chk("pready", 1, 0);
      give_verdict();
    end
  endtask : apb

  task automatic instr(input psc_instr_t k, input psc_sr_t s);
    @(posedge clk);
    instr_valid <= 1;
    instr_kind <= k;
    sr_wr_data <= s;
    @(posedge clk);
    instr_valid <= 0;
    #1;
  endtask : instr

  task automatic bref(input logic p);
    @(posedge clk);
    bus_start <= 1;
    bus_program <= p;
    @(posedge clk);
    bus_start <= 0;
    #1;
  endtask : bref

  task automatic fin_exc(input logic skip_save);
    if (!skip_save)
    begin
      wait_st(PSC_EXC_SAVE);
      @(posedge clk);
      save_done <= 1;
      @(posedge clk);
      save_done <= 0;
    end
    wait_st(PSC_EXC_LOAD);
    @(posedge clk);
    load_done <= 1;
    @(posedge clk);
    load_done <= 0;
    wait_st(PSC_NORMAL);
  endtask : fin_exc

  // ----
  // Scenarios
  // ----
  task automatic boot();
    @(posedge clk);
    rst_n <= 0;
    repeat (20) @(posedge clk);
    #1;
    chk("reset state", PSC_EXC_COPY, proc_state);
    chk("reset level", 1, supervisor);
    @(posedge clk);
    rst_n <= 1;
    fin_exc(1);
    chk("boot class", PSC_RC_SUP_PROG, ref_class);
    apb(0, PSC_OFF_STATE, 0);
    chk("reset sr", 5'h0F, rd[8:4]);
    apb(0, PSC_OFF_MASK, 0);
    chk("mask reset", PSC_MASK_RST, rd[4:0]);
    apb(0, 8'h0C, 0);
    chk("unmapped", 1, err);
    $display("test boot done");
  endtask : boot

  task automatic t_user();
    for (int k = 0; k < 4; k++)
    begin
      instr(4'h2, 5'h00);
      @(posedge clk);
      #1;
      chk("user level", 0, supervisor);
      instr(4'h0, 5'h08);
      chk("plain done", 1, instr_done);
      bref(1);
      chk("user prog", PSC_RC_USER_PROG, ref_class);
      bref(0);
      chk("user data", PSC_RC_USER_DATA, ref_class);
      chk("user stack", 1, sel_ustk);
      // Privileged kinds one by one, each asking to raise the flag
      instr(4'h1 << k, 5'h08);
      chk("refused", 1, instr_refused);
      chk("copy step", PSC_EXC_COPY, proc_state);
      wait_st(PSC_EXC_SAVE);
      chk("priv vector", 10'h020, vector_addr);
      chk("exc stack", 0, sel_ustk);
      bref(1);
      chk("exc class", PSC_RC_SUP_PROG, ref_class);
      fin_exc(0);
      apb(0, PSC_OFF_STATE, 0);
      chk("saved sr", 5'h00, rd[13:9]);
      chk("handler level", 1, rd[3]);
    end
    // A traced instruction still completes, then traps with trace cleared
    instr(4'h2, 5'h18);
    instr(4'h0, 5'h08);
    chk("traced done", 1, instr_done);
    chk("trace step", PSC_EXC_COPY, proc_state);
    wait_st(PSC_EXC_SAVE);
    chk("trace vector", 10'h024, vector_addr);
    fin_exc(0);
    apb(0, PSC_OFF_STATE, 0);
    chk("trace cleared", 5'h08, rd[8:4]);
    chk("trace saved", 5'h18, rd[13:9]);
    bref(0);
    chk("sup data", PSC_RC_SUP_DATA, ref_class);
    chk("sup stack", 0, sel_ustk);
    chk("irq masked", 0, irq);
    apb(1, PSC_OFF_MASK, 32'h0000_0001);
    @(posedge clk);
    #1;
    chk("irq raised", 1, irq);
    apb(0, PSC_OFF_EVENT, 0);
    chk("events", 5'h03, rd[4:0]);
    @(posedge clk);
    #1;
    chk("irq cleared", 0, irq);
    $display("test user done");
  endtask : t_user

  task automatic t_stop();
    instr(4'h8, 5'h0B);
    wait_st(PSC_STOPPED);
    @(posedge clk);
    #1;
    chk("no refs", 0, bus_enable);
    @(posedge clk);
    irq_level_pin <= 3'h5;
    iack_num <= 8'h40;
    slow <= 1;
    wait_st(PSC_EXC_VEC);
    bref(0);
    chk("iack class", PSC_RC_IACK, ref_class);
    @(posedge clk);
    irq_level_pin <= 3'h0;
    wait_st(PSC_EXC_SAVE);
    chk("int vector", 10'h100, vector_addr);
    apb(0, PSC_OFF_STATE, 0);
    chk("int sr", 5'h0D, rd[8:4]);
    fin_exc(0);
    $display("test stop done");
  endtask : t_stop

  task automatic t_halt();
    @(posedge clk);
    exc_req <= 1;
    exc_vector <= 8'h20;
    slow <= 0;
    fault_arm <= 1;
    @(posedge clk);
    exc_req <= 0;
    wait_st(PSC_EXC_SAVE);
    bref(0);
    wait_st(PSC_EXC_COPY);
    wait_st(PSC_EXC_SAVE);
    chk("berr vector", 10'h008, vector_addr);
    bref(0);
    wait_st(PSC_HALTED);
    // Instructions, exception request, step handshakes and level 7 are thrown at the halted core
    @(posedge clk);
    fault_arm <= 0;
    {instr_valid, exc_req, save_done, load_done} <= 4'hF;
    irq_level_pin <= 3'h7;
    repeat (8) @(posedge clk);
    {instr_valid, exc_req, save_done, load_done} <= 4'h0;
    irq_level_pin <= 3'h0;
    @(posedge clk);
    #1;
    chk("held", PSC_HALTED, proc_state);
    chk("halt refs", 0, bus_enable);
    apb(0, PSC_OFF_EVENT, 0);
    chk("halt event", 1, rd[2]);
    boot();
    $display("test halt done");
  endtask : t_halt

  initial
  begin
    {rst_n, psel, penable, pwrite, instr_valid, exc_req, save_done, load_done} = '0;
    {bus_start, bus_program, fault_arm, slow, err} = '0;
    {paddr, exc_vector, iack_num, pwdata, irq_level_pin, rd} = '0;
    instr_kind = '0;
    sr_wr_data = '0;
    n_fail = 0;
    total_checks = 0;
    boot();
    t_user();
    t_stop();
    t_halt();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
